// [shared/occ_defines.svh]
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// Register word addresses on the plain register port
`define OCC_ADDR_W        3
`define OCC_ADDR_CTRL     3'h0
`define OCC_ADDR_PRIMARY  3'h1
`define OCC_ADDR_SECOND   3'h2
`define OCC_ADDR_STATUS   3'h3
`define OCC_ADDR_MASK     3'h4

// Control register field positions
`define OCC_BIT_IDLE      13
`define OCC_BIT_FAULT     4
`define OCC_BIT_TSEL      3
`define OCC_MODE_MSB      2
`define OCC_MODE_LSB      0

// Interrupt status and mask bit positions
`define OCC_IRQ_W         2
`define OCC_IRQ_CMP       0
`define OCC_IRQ_FLT       1

// Reset values
`define OCC_ZERO16        16'h0000
`define OCC_ZERO_IRQ      2'h0

`endif

// [shared/occ_pkg.sv]
package occ_pkg;

  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_ONE_LOW  = 3'b001,
    MODE_ONE_HIGH = 3'b010,
    MODE_TOGGLE   = 3'b011,
    MODE_DELAYED  = 3'b100,
    MODE_PULSE    = 3'b101,
    MODE_PWM      = 3'b110,
    MODE_PWM_FLT  = 3'b111
  } mode_type;

  typedef struct packed {
    logic       idle_stop_bit;
    logic       timebase_select;
    mode_type   compare_mode_field;
  } ctrl_type;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic [15:0] count;
    logic        period_end;
  } timebase_type;

endpackage

// [logic/compare_match.sv]
`timescale 1ns/1ps
`default_nettype none

module compare_match #(
  parameter int WIDTH = 16
) (
  // Operands
  input  wire logic [WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0] value,
  // Result
  output wire logic             equal
);

  assign equal = (count == value);

endmodule

`default_nettype wire

// [logic/output_compare_channel.sv]
// Contract
// - Timebase select high picks the second timer, low picks the first.
// - Selected count is compared with one or two values; match changes the pin.
// - Compare matches can raise an interrupt, edge chosen by mode.
// - Mode 000: channel off, no interrupt, pin under port control.
// - Mode 001: start low, match drives high, interrupt on rising edge.
// - Mode 010: start high, match drives low, interrupt on falling edge.
// - Mode 011: keep level, toggle on each match, interrupt on both edges.
// - Mode 100: start low, one single pulse, interrupt on its falling edge.
// - Mode 101: start low, repeating pulses, interrupt on each falling edge.
// - Mode 110: PWM, no fault, no interrupt; PWM starts low iff primary zero.
// - Mode 111: PWM with fault input, interrupt on fault falling edge.
// - Fault status is read-only, set on PWM fault, cleared by hardware only.
// - Idle-stop bit high halts the channel during CPU idle.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"

module output_compare_channel
  import occ_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         ce,
  // Register port
  input  wire bus_req_type  bus_req,
  output logic [15:0]       rdata,
  // Timer time bases
  input  wire timebase_type first_timebase,
  input  wire timebase_type second_timebase,
  // System and pins
  input  wire logic         cpu_idle,
  input  wire logic         fault_input,
  input  wire logic         gpio_level,
  output logic              compare_output_pin,
  output wire logic         irq
);

  ctrl_type                ctrl_r;
  logic [15:0]             primary_r;
  logic [15:0]             secondary_r;
  logic [`OCC_IRQ_W-1:0]   stat_r;
  logic [`OCC_IRQ_W-1:0]   mask_r;
  logic                    out_r;
  logic                    done_r;
  logic                    flt_r;
  logic                    fault_prev_r;
  logic                    out_nxt;
  logic                    done_nxt;
  logic                    flt_nxt;
  logic [15:0]             rdata_nxt;

  // Decoding
  wire                     ctrl_wr;
  wire                     pri_wr;
  wire                     sec_wr;
  wire                     stat_wr;
  wire                     mask_wr;
  wire mode_type           mode;
  wire mode_type           wmode;
  wire timebase_type       tb;
  wire                     halted;
  wire                     active;
  wire                     is_pwm;
  wire                     m_pri;
  wire                     m_sec;
  wire                     rise;
  wire                     fall;
  wire                     cmp_ev;
  wire                     flt_ev;
  wire                     pwm_load;
  wire [`OCC_IRQ_W-1:0]    irq_set;
  wire [`OCC_IRQ_W-1:0]    irq_clr;
  wire [`OCC_IRQ_W-1:0]    stat_nxt;
  wire [15:0]              ctrl_rd;

  assign ctrl_wr  = bus_req.wr && (bus_req.addr == `OCC_ADDR_CTRL);
  assign pri_wr   = bus_req.wr && (bus_req.addr == `OCC_ADDR_PRIMARY);
  assign sec_wr   = bus_req.wr && (bus_req.addr == `OCC_ADDR_SECOND);
  assign stat_wr  = bus_req.wr && (bus_req.addr == `OCC_ADDR_STATUS);
  assign mask_wr  = bus_req.wr && (bus_req.addr == `OCC_ADDR_MASK);
  assign mode     = ctrl_r.compare_mode_field;
  assign wmode    = mode_type'(bus_req.wdata[`OCC_MODE_MSB:`OCC_MODE_LSB]);

  assign tb       = ctrl_r.timebase_select ? second_timebase : first_timebase;
  assign halted   = ctrl_r.idle_stop_bit && cpu_idle;
  assign active   = !halted && (mode != MODE_OFF);
  assign is_pwm   = (mode == MODE_PWM) || (mode == MODE_PWM_FLT);

  compare_match #(
    .WIDTH (16)
  ) u_match_primary (
    .count (tb.count),
    .value (primary_r),
    .equal (m_pri)
  );

  compare_match #(
    .WIDTH (16)
  ) u_match_secondary (
    .count (tb.count),
    .value (secondary_r),
    .equal (m_sec)
  );

  // Output behaviour per mode; a control write re-initialises the pin state
  always_comb begin
    out_nxt  = out_r;
    done_nxt = done_r;
    flt_nxt  = flt_r;
    if (ctrl_wr) begin
      done_nxt = 1'b0;
      flt_nxt  = 1'b0;
      unique case (wmode)
        MODE_OFF:      out_nxt = 1'b0;
        MODE_ONE_LOW:  out_nxt = 1'b0;
        MODE_ONE_HIGH: out_nxt = 1'b1;
        MODE_TOGGLE:   out_nxt = out_r;
        MODE_DELAYED:  out_nxt = 1'b0;
        MODE_PULSE:    out_nxt = 1'b0;
        MODE_PWM,
        MODE_PWM_FLT:  out_nxt = (primary_r != `OCC_ZERO16);
      endcase
    end else if (active) begin
      unique case (mode)
        MODE_OFF: begin
          out_nxt = out_r;
        end
        MODE_ONE_LOW: begin
          if (m_pri) begin
            out_nxt = 1'b1;
          end
        end
        MODE_ONE_HIGH: begin
          if (m_pri) begin
            out_nxt = 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (m_pri) begin
            out_nxt = !out_r;
          end
        end
        MODE_DELAYED: begin
          // Secondary wins only while the pulse is high, so with equal values the pulse still ends
          if (!done_r && m_sec && out_r) begin
            out_nxt  = 1'b0;
            done_nxt = 1'b1;
          end else if (!done_r && m_pri) begin
            out_nxt  = 1'b1;
          end
        end
        MODE_PULSE: begin
          if (m_sec) begin
            out_nxt = 1'b0;
          end else if (m_pri) begin
            out_nxt = 1'b1;
          end
        end
        MODE_PWM,
        MODE_PWM_FLT: begin
          if (tb.period_end) begin
            out_nxt = (secondary_r != `OCC_ZERO16);
          end else if (m_pri) begin
            out_nxt = 1'b0;
          end
          // A latched fault holds the output low until the mode is rewritten
          if ((mode == MODE_PWM_FLT) && (!fault_input || flt_r)) begin
            out_nxt = 1'b0;
            flt_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  // Interrupt events: edges of the compare state chosen by the mode, and the fault input falling edge
  assign rise   = out_nxt && !out_r;
  assign fall   = !out_nxt && out_r;
  assign cmp_ev = active && !ctrl_wr && (
                    ((mode == MODE_ONE_LOW) && rise) ||
                    ((mode == MODE_ONE_HIGH) && fall) ||
                    ((mode == MODE_TOGGLE) && (rise || fall)) ||
                    ((mode == MODE_DELAYED) && fall) ||
                    ((mode == MODE_PULSE) && fall));
  assign flt_ev = active && !ctrl_wr && (mode == MODE_PWM_FLT) &&
                  fault_prev_r && !fault_input;

  assign irq_set  = {flt_ev, cmp_ev};
  assign irq_clr  = stat_wr ? bus_req.wdata[`OCC_IRQ_W-1:0] : `OCC_ZERO_IRQ;
  assign stat_nxt = (stat_r & ~irq_clr) | irq_set;
  assign irq      = |(stat_r & mask_r);

  // Timer transfer loses to a software write in the same cycle
  assign pwm_load = active && is_pwm && tb.period_end && !pri_wr;

  assign ctrl_rd  = {2'h0, ctrl_r.idle_stop_bit, 8'h00, flt_r,
                     ctrl_r.timebase_select, ctrl_r.compare_mode_field};

  always_comb begin
    unique case (bus_req.addr)
      `OCC_ADDR_CTRL:    rdata_nxt = ctrl_rd;
      `OCC_ADDR_PRIMARY: rdata_nxt = primary_r;
      `OCC_ADDR_SECOND:  rdata_nxt = secondary_r;
      `OCC_ADDR_STATUS:  rdata_nxt = {14'h0000, stat_r};
      `OCC_ADDR_MASK:    rdata_nxt = {14'h0000, mask_r};
      default:           rdata_nxt = `OCC_ZERO16;
    endcase
  end

  // Registers; the timer must be stopped while these are rewritten
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= '0;
    end else if (ce && ctrl_wr) begin
      ctrl_r.idle_stop_bit      <= bus_req.wdata[`OCC_BIT_IDLE];
      ctrl_r.timebase_select    <= bus_req.wdata[`OCC_BIT_TSEL];
      ctrl_r.compare_mode_field <= wmode;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      primary_r <= `OCC_ZERO16;
    end else if (ce && pri_wr) begin
      primary_r <= bus_req.wdata;
    end else if (ce && pwm_load) begin
      primary_r <= secondary_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      secondary_r <= `OCC_ZERO16;
      mask_r      <= `OCC_ZERO_IRQ;
    end else if (ce) begin
      if (sec_wr) begin
        secondary_r <= bus_req.wdata;
      end
      if (mask_wr) begin
        mask_r <= bus_req.wdata[`OCC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat_r       <= `OCC_ZERO_IRQ;
      out_r        <= 1'b0;
      done_r       <= 1'b0;
      flt_r        <= 1'b0;
      fault_prev_r <= 1'b1;
    end else if (ce) begin
      stat_r       <= stat_nxt;
      out_r        <= out_nxt;
      done_r       <= done_nxt;
      flt_r        <= flt_nxt;
      fault_prev_r <= fault_input;
    end
  end

  // Pin follows the port level while the channel is off
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      compare_output_pin <= 1'b0;
      rdata              <= `OCC_ZERO16;
    end else if (ce) begin
      compare_output_pin <= (mode == MODE_OFF) ? gpio_level : out_r;
      if (bus_req.rd) begin
        rdata <= rdata_nxt;
      end else begin
        rdata <= `OCC_ZERO16;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn || !ce);

  sequence s_fault_seen;
    active && (mode == MODE_PWM_FLT) && !fault_input && !ctrl_wr;
  endsequence

  sequence s_fault_forced;
    !out_r && flt_r;
  endsequence

  sequence s_delayed_done;
    (mode == MODE_DELAYED) && done_r && !ctrl_wr;
  endsequence

  AST_TIMEBASE_SEL: assert property (
    (ctrl_r.timebase_select && (second_timebase.count == primary_r)) ||
    (!ctrl_r.timebase_select && (first_timebase.count == primary_r)) |-> m_pri)
    else $error("Selected timer not used for compare");

  AST_OFF_QUIET: assert property (
    (mode == MODE_OFF) |-> !cmp_ev && !flt_ev ##1 (compare_output_pin == $past(gpio_level)))
    else $error("Disabled channel not under port control");

  AST_ONE_LOW: assert property (
    active && (mode == MODE_ONE_LOW) && m_pri && !out_r && !ctrl_wr |=> out_r && stat_r[`OCC_IRQ_CMP])
    else $error("Active-low one-shot did not rise with interrupt");

  AST_ONE_HIGH: assert property (
    active && (mode == MODE_ONE_HIGH) && m_pri && out_r && !ctrl_wr |=> !out_r && stat_r[`OCC_IRQ_CMP])
    else $error("Active-high one-shot did not fall with interrupt");

  AST_TOGGLE: assert property (
    active && (mode == MODE_TOGGLE) && m_pri && !ctrl_wr |=> (out_r != $past(out_r)) && stat_r[`OCC_IRQ_CMP])
    else $error("Toggle mode did not invert the output");

  AST_DELAYED_ONCE: assert property (
    s_delayed_done [*2] |-> !out_r)
    else $error("Delayed one-shot produced a second pulse");

  AST_PULSE_FALL: assert property (
    active && (mode == MODE_PULSE) && m_sec && out_r && !ctrl_wr |=> !out_r && stat_r[`OCC_IRQ_CMP])
    else $error("Continuous pulse did not fall on secondary match");

  AST_PWM_NO_IRQ: assert property (
    is_pwm |-> !cmp_ev)
    else $error("PWM mode raised a compare interrupt");

  AST_PWM_LOAD: assert property (
    pwm_load |=> (primary_r == $past(secondary_r)))
    else $error("Duty value not transferred at period end");

  AST_FAULT: assert property (
    s_fault_seen |=> s_fault_forced ##0 (stat_r[`OCC_IRQ_FLT] || !$past(fault_prev_r)))
    else $error("Fault did not force output low and flag");

  AST_FAULT_HOLD: assert property (
    flt_r && !ctrl_wr |=> flt_r)
    else $error("Fault status cleared without a mode write");

  AST_IDLE_HALT: assert property (
    halted && !ctrl_wr |=> $stable(out_r) && $stable(done_r))
    else $error("Channel ran during CPU idle");

endmodule

`default_nettype wire

// [verif/pin_load.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  // Load side
  input  wire logic clk_sys,
  input  wire logic compare_output_pin,
  input  wire logic arm,
  // Open-drain fault line, pulled up when released
  output wire logic fault_input
);
  logic fault_r = 1'b1;
  // Overcurrent trips only while the pin drives the load high
  always @(posedge clk_sys) fault_r <= !(arm && compare_output_pin);
  assign fault_input = fault_r;
endmodule
`default_nettype wire

// [verif/output_compare_channel_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module output_compare_channel_tb import occ_pkg::*; ();
  logic         clk_sys    = 1'b0;
  logic         rstn       = 1'b0;
  logic         ce         = 1'b1;
  logic         cpu_idle   = 1'b0;
  logic         gpio_level = 1'b0;
  logic         arm        = 1'b0;
  logic         run        = 1'b0;
  logic         rd_d       = 1'b0;
  bus_req_type  bus_req    = '0;
  timebase_type tb1        = '0;
  timebase_type tb2        = '0;
  logic [15:0]  rdata;
  logic         compare_output_pin;
  wire logic    irq;
  wire logic    fault_input;
  logic [15:0]  p;
  logic [15:0]  rq[$];
  logic [31:0]  lfsr       = 32'hfbdf9f5c;
  int           n_errors   = 0;
  int           n_checks   = 0;

  output_compare_channel u_dut (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .ce                 (ce),
    .bus_req            (bus_req),
    .rdata              (rdata),
    .first_timebase     (tb1),
    .second_timebase    (tb2),
    .cpu_idle           (cpu_idle),
    .fault_input        (fault_input),
    .gpio_level         (gpio_level),
    .compare_output_pin (compare_output_pin),
    .irq                (irq)
  );
  pin_load u_load (.clk_sys(clk_sys), .compare_output_pin(compare_output_pin),
                   .arm(arm), .fault_input(fault_input));

  always #5 clk_sys = ~clk_sys;

  // Timers restart from fixed, different phases so the two bases do not agree until 250 cycles into a run
  always @(posedge clk_sys) begin
    tb1.count      <= !run ? 16'h0000 : (tb1.count == 16'h0031) ? 16'h0000 : tb1.count + 16'h0001;
    tb1.period_end <= run && tb1.count == 16'h0030;
    tb2.count      <= !run ? 16'h001e : (tb2.count == 16'h0045) ? 16'h0000 : tb2.count + 16'h0001;
    tb2.period_end <= run && tb2.count == 16'h0044;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= bus_req.rd;
    if (rd_d) check(rdata, rq.pop_front());
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    rq.push_back(e);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask

  // Timer is stopped around every control write
  task automatic cfg(input logic [15:0] c, input logic init);
    run <= 1'b0;
    wr(3'h3, 16'h0003);
    wr(3'h0, c);
    run <= 1'b1;
    @(posedge clk_sys);
    check(compare_output_pin, init);
  endtask

  // Pin shows a match two edges after the count is presented
  task automatic wait_pin(input logic lv, input logic sel, input logic [15:0] c);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (compare_output_pin === lv) break;
    end
    if (i == 400) begin
      n_errors++;
      report_and_stop();
    end else begin
      check(sel ? tb2.count : tb1.count, c);
      @(posedge clk_sys);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 6; a++) rd(a[2:0], 16'h0000);
    wr(3'h5, 16'hffff);
    rd(3'h5, 16'h0000);
    wr(3'h0, 16'hffff);
    rd(3'h0, 16'h200f);
    wr(3'h0, 16'h0000);
    wr(3'h4, 16'h0003);
    rd(3'h4, 16'h0003);
    // Clock enable low: the write is ignored and the pin holds its level
    ce         <= 1'b0;
    gpio_level <= !gpio_level;
    wr(3'h4, 16'h0000);
    check(compare_output_pin, !gpio_level);
    ce         <= 1'b1;
    rd(3'h4, 16'h0003);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      gpio_level <= lfsr[0];
      @(posedge clk_sys);
      @(posedge clk_sys);
      check(compare_output_pin, lfsr[0]);
      check(irq, 1'b0);
    end
    $display("test off mode done");
    lfsr = lfsr_next(lfsr);
    p = 16'h0005 + {12'h000, lfsr[3:0]};
    wr(3'h1, p);
    cfg(16'h0009, 1'b0);
    wait_pin(1'b1, 1'b1, p + 16'h0002);
    rd(3'h3, 16'h0001);
    check(irq, 1'b1);
    wr(3'h3, 16'h0001);
    check(irq, 1'b0);
    cfg(16'h0002, 1'b1);
    wait_pin(1'b0, 1'b0, p + 16'h0002);
    rd(3'h3, 16'h0001);
    $display("test one-shot done");
    wr(3'h4, 16'h0000);
    cfg(16'h0003, 1'b0);
    wait_pin(1'b1, 1'b0, p + 16'h0002);
    wait_pin(1'b0, 1'b0, p + 16'h0002);
    rd(3'h3, 16'h0001);
    check(irq, 1'b0);
    wr(3'h4, 16'h0003);
    cfg(16'h2003, 1'b0);
    cpu_idle <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check(compare_output_pin, 1'b0);
    cpu_idle <= 1'b0;
    wait_pin(1'b1, 1'b0, p + 16'h0002);
    cfg(16'h0003, 1'b1);
    cpu_idle <= 1'b1;
    wait_pin(1'b0, 1'b0, p + 16'h0002);
    cpu_idle <= 1'b0;
    $display("test toggle and idle done");
    wr(3'h2, p + 16'h000a);
    cfg(16'h0005, 1'b0);
    wait_pin(1'b1, 1'b0, p + 16'h0002);
    wait_pin(1'b0, 1'b0, p + 16'h000c);
    rd(3'h3, 16'h0001);
    wait_pin(1'b1, 1'b0, p + 16'h0002);
    cfg(16'h0004, 1'b0);
    wait_pin(1'b1, 1'b0, p + 16'h0002);
    wait_pin(1'b0, 1'b0, p + 16'h000c);
    repeat (44) @(posedge clk_sys);
    check(compare_output_pin, 1'b0);
    rd(3'h3, 16'h0001);
    $display("test pulse done");
    wr(3'h1, 16'h0000);
    cfg(16'h0006, 1'b0);
    wr(3'h1, p);
    cfg(16'h0006, 1'b1);
    wait_pin(1'b0, 1'b0, p + 16'h0002);
    wait_pin(1'b1, 1'b0, 16'h0001);
    wait_pin(1'b0, 1'b0, p + 16'h000c);
    rd(3'h1, p + 16'h000a);
    rd(3'h3, 16'h0000);
    $display("test pwm done");
    cfg(16'h0007, 1'b1);
    arm <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(compare_output_pin, 1'b0);
    arm <= 1'b0;
    rd(3'h0, 16'h0017);
    rd(3'h3, 16'h0002);
    check(irq, 1'b1);
    repeat (60) @(posedge clk_sys);
    check(compare_output_pin, 1'b0);
    rd(3'h0, 16'h0017);
    cfg(16'h0000, gpio_level);
    rd(3'h0, 16'h0000);
    $display("test fault done");
    report_and_stop();
  end
endmodule
`default_nettype wire
